// ==== btc_map.vh ====
// register map, field positions and reset values of the basic timer control block
`ifndef BTC_MAP_VH
`define BTC_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BTC_OFF_CTRL1   6'h00
`define BTC_OFF_CTRL2   6'h04
`define BTC_OFF_DIE     6'h0c
`define BTC_OFF_STS     6'h10
`define BTC_OFF_EVG     6'h14
`define BTC_OFF_SMC     6'h18
`define BTC_OFF_CNT     6'h24
`define BTC_OFF_DIV     6'h28
`define BTC_OFF_AR      6'h2c
// ----------------------------------------
// field positions
// ----------------------------------------
`define BTC_B_CEN       0
`define BTC_B_UDIS      1
`define BTC_B_USRC      2
`define BTC_B_OPM       3
`define BTC_B_ARPE      7
`define BTC_B_MMS_LO    4
`define BTC_B_MMS_HI    6
`define BTC_B_UIE       0
`define BTC_B_UDE       8
`define BTC_B_UFLAG     0
`define BTC_B_UG        0
`define BTC_B_SMS_LO    0
`define BTC_B_SMS_HI    2
`define BTC_B_MSM       7
// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define BTC_MMS_RESET   3'h0
`define BTC_MMS_ENABLE  3'h1
`define BTC_MMS_UPDATE  3'h2
`define BTC_SMS_OFF     3'h0
`define BTC_SMS_RESET   3'h4
`define BTC_SMS_GATED   3'h5
`define BTC_SMS_TRIG    3'h6
`define BTC_RST16       16'h0000
`define BTC_ONE16       16'h0001
`endif

// ==== btc_sync.v ====
// three-stage synchroniser for the trigger input pin
`timescale 1ns/1ps
module btc_sync (
   // clock and reset
   input  wire sys_clk,
   input  wire sys_rst,
   // pin and filtered level
   input  wire pin_in,
   output reg  level_out,
   output reg  rise_out
);
   reg s1;
   reg s2;
   reg s3;
   // s1 feeds s2 only; level changes once s2 and s3 agree
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         s1        <= 1'b0;
         s2        <= 1'b0;
         s3        <= 1'b0;
         level_out <= 1'b0;
         rise_out  <= 1'b0;
      end else begin
         s1       <= pin_in;
         s2       <= s1;
         s3       <= s2;
         rise_out <= 1'b0;
         if (s2 == s3 && s3 != level_out) begin
            level_out <= s3;
            rise_out  <= s3;
         end
      end
   end
endmodule // btc_sync

// ==== btc_timer.v ====
// basic 16-bit up timer: control registers, time base and trigger output
// Summary of operation
// - preload bit buffers auto-reload until update
// - single-shot clears counter enable at update
// - source select 0: all updates flag
// - source select 1: only overflow flags
// - update inhibit 0: overflow/strobe/slave make updates
// - update copies preload into shadow registers
// - update inhibit 1: no update, buffered shadows hold
// - strobe or slave reset still reinitialises counter
// - counter enable bit starts and stops counting
// - trigger mode sets enable bit on trigger
// - trigger select 000 outputs software strobe
// - code 000 output lags slave reset
// - trigger select 001 outputs effective enable
// - effective enable is bit OR gated trigger
// - trigger path delayed unless sync option set
// - trigger select 010 outputs update event
// - dma enable bit gates update dma request
// - irq enable bit gates update interrupt
// - reserved bits read as zero
// - effective enable follows bit one cycle later
// - update flag sticky until software clears
// - strobe reinitialises, updates, self-clears
// - count zero to reload, wrap, overflow
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "btc_map.vh"
module btc_timer (
   // clock and reset
   input  wire        sys_clk,
   input  wire        sys_rst,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [5:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // trigger link
   input  wire        trigger_input,
   output reg         trigger_output,
   // update requests
   output reg         update_irq,
   output reg         update_dma_req,
   // counter view
   output reg  [15:0] counter_value
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   // control fields written by software
   reg        counter_enable_bit;
   reg        update_inhibit;
   reg        update_source_select;
   reg        single_shot_select;
   reg        preload_buffer_select;
   reg [2:0]  trigger_out_select;
   reg        update_irq_enable;
   reg        update_dma_enable;
   reg [2:0]  slave_mode;
   reg        master_slave_sync_option;

   // event state set by hardware, except the strobe, set by a software write
   reg        update_flag;
   reg        software_update_strobe;
   reg        slave_reset_late;

   // preload values and the copies the time base uses
   reg [15:0] auto_reload_value;
   reg [15:0] ar_shadow;
   reg [15:0] prescaler_ratio;
   reg [15:0] div_shadow;

   // time base and enable pipeline
   reg [15:0] div_count;
   reg        effective_count_enable;
   reg        enable_delayed;

   // synchronised trigger pin
   wire       trig_level;
   wire       trig_rise;

   // trigger pin synchroniser
   btc_sync u_sync (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .pin_in    (trigger_input),
      .level_out (trig_level),
      .rise_out  (trig_rise)
   );

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   // a request is taken once; the pending ack blocks a second take
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr      = bus_req & wb_we_i;

   // byte-lane aware write of a 16-bit register
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] dat;
      input [3:0]  sel;
      begin
         merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
      end
   endfunction

   // write hit test for one offset
   function hit;
      input [5:0] adr;
      input [5:0] off;
      begin
         hit = (adr[5:2] == off[5:2]);
      end
   endfunction

   // ----------------------------------------
   // register write strobes
   // ----------------------------------------
   // one strobe per decoded offset
   wire w_ctrl1 = wr & hit(wb_adr_i, `BTC_OFF_CTRL1);
   wire w_ctrl2 = wr & hit(wb_adr_i, `BTC_OFF_CTRL2);
   wire w_die   = wr & hit(wb_adr_i, `BTC_OFF_DIE);
   wire w_sts   = wr & hit(wb_adr_i, `BTC_OFF_STS);
   wire w_evg   = wr & hit(wb_adr_i, `BTC_OFF_EVG);
   wire w_smc   = wr & hit(wb_adr_i, `BTC_OFF_SMC);
   wire w_cnt   = wr & hit(wb_adr_i, `BTC_OFF_CNT);
   wire w_div   = wr & hit(wb_adr_i, `BTC_OFF_DIV);
   wire w_ar    = wr & hit(wb_adr_i, `BTC_OFF_AR);
   wire [15:0] wdat = merge16(`BTC_RST16, wb_dat_i, wb_sel_i);

   // ----------------------------------------
   // event generation
   // ----------------------------------------
   // slave mode decode
   wire gated_mode   = (slave_mode == `BTC_SMS_GATED);
   wire trig_mode    = (slave_mode == `BTC_SMS_TRIG);
   wire slave_reset  = (slave_mode == `BTC_SMS_RESET) & trig_rise;
   // effective enable before the one-cycle register
   wire enable_req   = counter_enable_bit | (gated_mode & trig_level);
   // prescaler wrap; a zero reload value holds the counter still
   wire prescale_tc  = (div_count == div_shadow);
   wire tick         = effective_count_enable & prescale_tc & (ar_shadow != `BTC_RST16);
   wire overflow     = tick & (counter_value == ar_shadow);
   // counter reinitialisation requests, honoured even when inhibited
   wire reinit       = software_update_strobe | slave_reset;
   // update event: inhibit suppresses all sources
   wire update_event = ~update_inhibit & (overflow | reinit);
   // update event that is allowed to raise the flag
   wire flag_event   = update_event & (~update_source_select | overflow);

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         counter_enable_bit       <= 1'b0;
         update_inhibit           <= 1'b0;
         update_source_select     <= 1'b0;
         single_shot_select       <= 1'b0;
         preload_buffer_select    <= 1'b0;
         trigger_out_select       <= `BTC_MMS_RESET;
         update_irq_enable        <= 1'b0;
         update_dma_enable        <= 1'b0;
         slave_mode               <= `BTC_SMS_OFF;
         master_slave_sync_option <= 1'b0;
         software_update_strobe   <= 1'b0;
      end else begin
         // byte lane 0 carries every control field here except the dma enable, which rides lane 1
         if (w_ctrl1 & wb_sel_i[0]) begin
            counter_enable_bit    <= wdat[`BTC_B_CEN];
            update_inhibit        <= wdat[`BTC_B_UDIS];
            update_source_select  <= wdat[`BTC_B_USRC];
            single_shot_select    <= wdat[`BTC_B_OPM];
            preload_buffer_select <= wdat[`BTC_B_ARPE];
         end
         // hardware set wins over a software write in the same cycle
         if (trig_mode & trig_rise)
            counter_enable_bit <= 1'b1;
         else if (update_event & single_shot_select)
            counter_enable_bit <= 1'b0;
         if (w_ctrl2 & wb_sel_i[0])
            trigger_out_select <= wdat[`BTC_B_MMS_HI:`BTC_B_MMS_LO];
         // each enable follows its own byte lane
         if (w_die & wb_sel_i[0])
            update_irq_enable <= wdat[`BTC_B_UIE];
         if (w_die & wb_sel_i[1])
            update_dma_enable <= wdat[`BTC_B_UDE];
         if (w_smc & wb_sel_i[0]) begin
            slave_mode               <= wdat[`BTC_B_SMS_HI:`BTC_B_SMS_LO];
            master_slave_sync_option <= wdat[`BTC_B_MSM];
         end
         // strobe lives one cycle, then clears itself
         software_update_strobe <= w_evg & wdat[`BTC_B_UG];
      end
   end

   // ----------------------------------------
   // update flag
   // ----------------------------------------
   // software writes 0 to clear; a same-cycle event keeps it set
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         update_flag <= 1'b0;
      end else if (flag_event) begin
         update_flag <= 1'b1;
      end else if (w_sts & wb_sel_i[0] & ~wb_dat_i[`BTC_B_UFLAG]) begin
         update_flag <= 1'b0;
      end
   end

   // ----------------------------------------
   // preload and shadow registers
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         auto_reload_value <= `BTC_RST16;
         ar_shadow         <= `BTC_RST16;
         prescaler_ratio   <= `BTC_RST16;
         div_shadow        <= `BTC_RST16;
      end else begin
         // preload registers follow every bus write
         if (w_ar)
            auto_reload_value <= merge16(auto_reload_value, wb_dat_i, wb_sel_i);
         if (w_div)
            prescaler_ratio <= merge16(prescaler_ratio, wb_dat_i, wb_sel_i);
         // unbuffered reload follows the preload at once
         if (~preload_buffer_select)
            ar_shadow <= w_ar ? merge16(auto_reload_value, wb_dat_i, wb_sel_i)
                              : auto_reload_value;
         // update copies both preloads; inhibited updates never get here
         if (update_event) begin
            ar_shadow  <= auto_reload_value;
            div_shadow <= prescaler_ratio;
         end
      end
   end

   // ----------------------------------------
   // enable pipeline, prescaler and counter
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         effective_count_enable <= 1'b0;
         enable_delayed         <= 1'b0;
         slave_reset_late       <= 1'b0;
         div_count              <= `BTC_RST16;
         counter_value          <= `BTC_RST16;
      end else begin
         // enable register, plus a copy for the gated path
         effective_count_enable <= enable_req;
         enable_delayed         <= effective_count_enable;
         // slave reset seen once more a cycle on, for the trigger output
         slave_reset_late       <= slave_reset;
         // reinit beats a bus write, which beats counting
         if (reinit) begin
            div_count     <= `BTC_RST16;
            counter_value <= `BTC_RST16;
         end else if (w_cnt) begin
            counter_value <= merge16(counter_value, wb_dat_i, wb_sel_i);
         end else if (effective_count_enable) begin
            div_count <= prescale_tc ? `BTC_RST16 : div_count + `BTC_ONE16;
            if (tick)
               counter_value <= overflow ? `BTC_RST16
                                         : counter_value + `BTC_ONE16;
         end
         if (w_div & ~reinit & div_count > merge16(prescaler_ratio, wb_dat_i, wb_sel_i))
            div_count <= div_count;
      end
   end

   // ----------------------------------------
   // trigger output and requests
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         trigger_output <= 1'b0;
         update_irq     <= 1'b0;
         update_dma_req <= 1'b0;
      end else begin
         case (trigger_out_select)
            // slave reset taken one stage late, so the pulse trails the clear
            `BTC_MMS_RESET:  trigger_output <= software_update_strobe | slave_reset_late;
            // extra stage on the trigger-driven path unless synchronised
            `BTC_MMS_ENABLE: trigger_output <= (gated_mode & ~master_slave_sync_option)
                                               ? enable_delayed
                                               : effective_count_enable;
            `BTC_MMS_UPDATE: trigger_output <= update_event;
            default:         trigger_output <= 1'b0;
         endcase
         // requests follow the flag, from its setting edge on
         update_irq     <= (update_flag | flag_event) & update_irq_enable;
         update_dma_req <= (update_flag | flag_event) & update_dma_enable;
      end
   end

   // ----------------------------------------
   // read mux and acknowledge
   // ----------------------------------------
   // unused and reserved bits stay zero
   reg [15:0] rdat;
   always @* begin
      rdat = `BTC_RST16;
      case ({wb_adr_i[5:2], 2'h0})
         `BTC_OFF_CTRL1: begin
            rdat[`BTC_B_CEN]  = counter_enable_bit;
            rdat[`BTC_B_UDIS] = update_inhibit;
            rdat[`BTC_B_USRC] = update_source_select;
            rdat[`BTC_B_OPM]  = single_shot_select;
            rdat[`BTC_B_ARPE] = preload_buffer_select;
         end
         `BTC_OFF_CTRL2: rdat[`BTC_B_MMS_HI:`BTC_B_MMS_LO] = trigger_out_select;
         `BTC_OFF_DIE: begin
            rdat[`BTC_B_UIE] = update_irq_enable;
            rdat[`BTC_B_UDE] = update_dma_enable;
         end
         `BTC_OFF_STS: rdat[`BTC_B_UFLAG] = update_flag;
         `BTC_OFF_SMC: begin
            rdat[`BTC_B_SMS_HI:`BTC_B_SMS_LO] = slave_mode;
            rdat[`BTC_B_MSM] = master_slave_sync_option;
         end
         `BTC_OFF_CNT:      rdat = counter_value;
         `BTC_OFF_DIV:      rdat = prescaler_ratio;
         `BTC_OFF_AR:       rdat = auto_reload_value;
         default:           rdat = `BTC_RST16;
      endcase
   end

   // one wait-free ack per request, data registered with it
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= {`BTC_RST16, `BTC_RST16};
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= {`BTC_RST16, rdat};
      end
   end
endmodule // btc_timer

// ==== btc_monitor.sv ====
// port-level assertion checker for the basic timer control block
`timescale 1ns/1ps
module btc_monitor (
   // clock and reset
   input wire        sys_clk,
   input wire        sys_rst,
   // register bus
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [5:0]  wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   // trigger link, requests, counter
   input wire        trigger_input,
   input wire        trigger_output,
   input wire        update_irq,
   input wire        update_dma_req,
   input wire [15:0] counter_value
);
   logic [2:0] mms;
   logic       ie;
   logic       de;
   logic       udis;
   wire        wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // shadows of fields only software writes
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mms  <= 3'h0;
         ie   <= 1'b0;
         de   <= 1'b0;
         udis <= 1'b0;
      end else if (wr) begin
         if (wb_adr_i == 6'h04 && wb_sel_i[0]) mms <= wb_dat_i[6:4];
         if (wb_adr_i == 6'h00 && wb_sel_i[0]) udis <= wb_dat_i[1];
         if (wb_adr_i == 6'h0c && wb_sel_i[0]) ie <= wb_dat_i[0];
         if (wb_adr_i == 6'h0c && wb_sel_i[1]) de <= wb_dat_i[8];
      end
   end
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   a_read_reserved: assert property (
      wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:16] == 16'h0000 &&
      ($past(wb_adr_i) != 6'h00 || (wb_dat_o[15:8] == 8'h00 && wb_dat_o[6:4] == 3'h0)))
      else $error("reserved bits read nonzero");
   a_irq_gate: assert property (update_irq |-> $past(ie))
      else $error("irq without its enable");
   a_dma_gate: assert property (update_dma_req |-> $past(de))
      else $error("dma request without its enable");
   a_irq_sticky: assert property (
      update_irq && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> update_irq)
      else $error("irq dropped without software");
   a_count_step: assert property (
      !$stable(counter_value) && !$past(wr) |->
      counter_value == $past(counter_value) + 16'h0001 || counter_value == 16'h0000)
      else $error("counter jumped");
   a_trg_strobe: assert property (
      wr && wb_adr_i == 6'h14 && wb_sel_i[0] && wb_dat_i[0] && mms == 3'h0
      |-> ##[1:4] trigger_output)
      else $error("strobe not on trigger output");
   a_trg_quiet: assert property ((mms == 3'h2 && udis)[*4] |-> !trigger_output)
      else $error("update pulse while inhibited");
   // main scenarios reached
   c_irq: cover property (update_irq && update_dma_req);
   c_trg: cover property ($rose(trigger_output));
   c_read: cover property (wb_ack_o && !$past(wb_we_i));
endmodule // btc_monitor

bind btc_timer btc_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .trigger_input(trigger_input), .trigger_output(trigger_output), .update_irq(update_irq),
   .update_dma_req(update_dma_req), .counter_value(counter_value));

// ==== btc_slave_model.sv ====
// slave timer model: counts trigger pulses and drives a gate level back
`timescale 1ns/1ps
module btc_slave_model (
   // clock and reset
   input  wire        sys_clk,
   input  wire        sys_rst,
   // link
   input  wire        trigger_output,
   input  wire        gate_req,
   output logic       trigger_input,
   // observed pulses
   output logic [7:0] pulse_count
);
   logic last_trg;
   // rising edges count like a slave prescaler input
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         last_trg      <= 1'b0;
         pulse_count   <= 8'h00;
         trigger_input <= 1'b0;
      end else begin
         last_trg      <= trigger_output;
         trigger_input <= gate_req;
         if (trigger_output && !last_trg) pulse_count <= pulse_count + 8'h01;
      end
   end
endmodule // btc_slave_model

// ==== btc_timer_test.sv ====
// self-checking bench for the basic timer control block
`timescale 1ns/1ps
`include "btc_map.vh"
`define BTC_CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH %0t got %h want %h", $time, (g), (e)); end end
module btc_timer_test;
   logic        sys_clk  = 1'b0;
   logic        sys_rst  = 1'b1;
   logic        cyc      = 1'b0;
   logic        stb      = 1'b0;
   logic        we       = 1'b0;
   logic [5:0]  adr      = 6'h00;
   logic [3:0]  sel      = 4'h0;
   logic [31:0] wdat     = 32'h0;
   logic        gate_req = 1'b0;
   wire  [31:0] rdat;
   wire         ack;
   wire         trg_in;
   wire         trg_out;
   wire         irq;
   wire         dma;
   wire  [15:0] cnt;
   wire  [7:0]  pulses;
   logic [31:0] rd;
   logic [15:0] v;
   logic [7:0]  p;
   int          miscompares = 0;
   int          cmp_count   = 0;
   int          cycles      = 0;
   btc_timer uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .trigger_input(trg_in), .trigger_output(trg_out),
      .update_irq(irq), .update_dma_req(dma), .counter_value(cnt));
   btc_slave_model peer (.sys_clk(sys_clk), .sys_rst(sys_rst), .trigger_output(trg_out),
      .gate_req(gate_req), .trigger_input(trg_in), .pulse_count(pulses));
   // clock and hang guard
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   // verdict and end of run
   task automatic complete_run();
      if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   // one classic cycle; read data lands in rd
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= 4'h3;
      wdat <= d;
      while (ack !== 1'b1)
         @(posedge sys_clk);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      tick(16);
      sys_rst <= 1'b0;
      bus(0, `BTC_OFF_DIE, 32'h0); `BTC_CHK(rd, 32'h0000_0000)
      bus(1, `BTC_OFF_CTRL1, 32'hFFFF_FF8E);
      bus(0, `BTC_OFF_CTRL1, 32'h0); `BTC_CHK(rd, 32'h0000_008E)
      bus(1, `BTC_OFF_CTRL2, 32'hFFFF_FFFF);
      bus(0, `BTC_OFF_CTRL2, 32'h0); `BTC_CHK(rd, 32'h0000_0070)
      bus(1, `BTC_OFF_DIE, 32'hFFFF_FFFF);
      bus(0, `BTC_OFF_DIE, 32'h0); `BTC_CHK(rd, 32'h0000_0101)
      bus(1, 6'h08, 32'hFFFF_FFFF);
      bus(0, 6'h08, 32'h0); `BTC_CHK(rd, 32'h0000_0000)
      // count with enable routed out
      bus(1, `BTC_OFF_DIE, 32'h0);
      bus(1, `BTC_OFF_CTRL1, 32'h0);
      bus(1, `BTC_OFF_CTRL2, 32'h0000_0010);
      bus(1, `BTC_OFF_AR, 32'h0000_0005);
      bus(1, `BTC_OFF_EVG, 32'h0000_0001);
      bus(1, `BTC_OFF_CTRL1, 32'h0000_0001);
      `BTC_CHK(trg_out, 1'b0)
      tick(1); `BTC_CHK(trg_out, 1'b0)
      tick(1); `BTC_CHK(trg_out, 1'b1)
      v = 16'h0000;
      repeat (30) begin
         @(posedge sys_clk);
         if (cnt > v) v = cnt;
      end
      `BTC_CHK(v, 16'h0005)
      bus(1, `BTC_OFF_CTRL1, 32'h0);
      tick(3); `BTC_CHK(trg_out, 1'b0)
      v = cnt;
      tick(10); `BTC_CHK(cnt, v)
      // update flag, interrupt and dma gating
      bus(1, `BTC_OFF_DIE, 32'h0000_0101);
      bus(1, `BTC_OFF_STS, 32'h0);
      bus(1, `BTC_OFF_CNT, 32'h0000_0003);
      bus(1, `BTC_OFF_EVG, 32'h0000_0001);
      tick(6); `BTC_CHK({irq, dma}, 2'b11)
      `BTC_CHK(cnt, 16'h0000)
      bus(0, `BTC_OFF_EVG, 32'h0); `BTC_CHK(rd, 32'h0000_0000)
      bus(1, `BTC_OFF_DIE, 32'h0000_0100);
      tick(3); `BTC_CHK({irq, dma}, 2'b01)
      bus(1, `BTC_OFF_DIE, 32'h0000_0001);
      tick(3); `BTC_CHK({irq, dma}, 2'b10)
      bus(1, `BTC_OFF_STS, 32'h0);
      tick(3); `BTC_CHK(irq, 1'b0)
      // source select, trigger codes, inhibit
      bus(1, `BTC_OFF_CTRL1, 32'h0000_0004);
      bus(1, `BTC_OFF_CTRL2, 32'h0);
      p = pulses;
      bus(1, `BTC_OFF_EVG, 32'h0000_0001);
      tick(6); `BTC_CHK(irq, 1'b0)
      `BTC_CHK(pulses, p + 8'h01)
      bus(1, `BTC_OFF_CTRL2, 32'h0000_0020);
      bus(1, `BTC_OFF_EVG, 32'h0000_0001);
      tick(6); `BTC_CHK(pulses, p + 8'h02)
      bus(1, `BTC_OFF_CTRL1, 32'h0000_0006);
      bus(1, `BTC_OFF_CNT, 32'h0000_0003);
      bus(1, `BTC_OFF_EVG, 32'h0000_0001);
      tick(6); `BTC_CHK(pulses, p + 8'h02)
      `BTC_CHK(cnt, 16'h0000)
      // gated and trigger slave modes
      bus(1, `BTC_OFF_CTRL1, 32'h0);
      bus(1, `BTC_OFF_CTRL2, 32'h0000_0010);
      bus(1, `BTC_OFF_SMC, 32'h0000_0005);
      gate_req <= 1'b1;
      tick(8); `BTC_CHK(trg_out, 1'b0)
      tick(2); `BTC_CHK(trg_out, 1'b1)
      gate_req <= 1'b0;
      tick(10); `BTC_CHK(trg_out, 1'b0)
      bus(1, `BTC_OFF_SMC, 32'h0000_0085);
      gate_req <= 1'b1;
      tick(8); `BTC_CHK(trg_out, 1'b1)
      gate_req <= 1'b0;
      tick(10);
      bus(1, `BTC_OFF_SMC, 32'h0000_0006);
      gate_req <= 1'b1;
      tick(10);
      bus(0, `BTC_OFF_CTRL1, 32'h0); `BTC_CHK(rd[0], 1'b1)
      gate_req <= 1'b0;
      // single shot stops at the wrap
      bus(1, `BTC_OFF_SMC, 32'h0);
      bus(1, `BTC_OFF_CNT, 32'h0);
      bus(1, `BTC_OFF_CTRL1, 32'h0000_0009);
      tick(40);
      bus(0, `BTC_OFF_CTRL1, 32'h0); `BTC_CHK(rd, 32'h0000_0008)
      // slave reset mode clears the counter, pulse follows
      bus(1, `BTC_OFF_CTRL2, 32'h0);
      bus(1, `BTC_OFF_SMC, 32'h0000_0004);
      bus(1, `BTC_OFF_CNT, 32'h0000_0003);
      p = pulses;
      gate_req <= 1'b1;
      tick(12); `BTC_CHK(cnt, 16'h0000)
      `BTC_CHK(pulses, p + 8'h01)
      gate_req <= 1'b0;
      // buffered reload only lands at the next update
      bus(1, `BTC_OFF_SMC, 32'h0);
      bus(1, `BTC_OFF_CTRL1, 32'h0000_0080);
      bus(1, `BTC_OFF_AR, 32'h0000_0003);
      bus(1, `BTC_OFF_CNT, 32'h0000_0004);
      bus(1, `BTC_OFF_CTRL1, 32'h0000_0081);
      tick(20); `BTC_CHK(cnt <= 16'h0003, 1'b1)
      complete_run();
   end
endmodule // btc_timer_test
